// >>> bfce_defines.vh
// Constants for the flash boot command engine
`ifndef BFCE_DEFINES_VH
`define BFCE_DEFINES_VH

// ==========
// Command tags and frame bytes
`define BFCE_TAG_PROP_WR   8'h0C
`define BFCE_TAG_ERASE_ALL 8'h01
`define BFCE_TAG_REGION    8'h02
`define BFCE_TAG_UNLOCK    8'h0D
`define BFCE_TAG_READ      8'h03
`define BFCE_FRM_START     8'h5A
`define BFCE_FRM_CMD_TYPE  8'hA4
`define BFCE_HDR_BYTES     16'h0004

// ==========
// Properties and memory identifiers
`define BFCE_PROP_VERIFY   32'h0000000A
`define BFCE_PROP_MAX      32'h00000019
`define BFCE_MEM_INT       32'h00000000
`define BFCE_MEM_EXT       32'h00000001
`define BFCE_VERIFY_RST    1'h0

// ==========
// Status codes
`define BFCE_ST_OK         32'h00000000
`define BFCE_ST_INVARG     32'h00000004
`define BFCE_ST_ALIGN      32'h00000065
`define BFCE_ST_ADDR       32'h00000066
`define BFCE_ST_ACCESS     32'h00000067
`define BFCE_ST_PROT       32'h00000068
`define BFCE_ST_FAIL       32'h00000069
`define BFCE_ST_UNKPROP    32'h000003E8
`define BFCE_ST_READONLY   32'h000003E9
`define BFCE_ST_UNKCMD     32'h00002710
`define BFCE_ST_RANGE      32'h000027D8

// ==========
// Security byte layout
`define BFCE_SEC_ADDR      32'h0000040C
`define BFCE_SEC_UNSEC     8'hFE
`define BFCE_SEC_RST       8'hFF
`define BFCE_SEC_LSB       0
`define BFCE_SEC_OPEN      2'h2
`define BFCE_MASS_ERASE_ENABLE_BIT_LSB      4
`define BFCE_MASS_ERASE_ENABLE_BIT_OFF      2'h2

// ==========
// Flash operation codes
`define BFCE_FC_ERASE_INT  3'h1
`define BFCE_FC_ERASE_EXT  3'h2
`define BFCE_FC_REGION     3'h3
`define BFCE_FC_UNLOCK     3'h4
`define BFCE_FC_PROG       3'h5

// ==========
// Register byte offsets and status bits
`define BFCE_OFF_CTRL      6'h00
`define BFCE_OFF_HDR       6'h04
`define BFCE_OFF_FRAME     6'h08
`define BFCE_OFF_PARAM0    6'h0C
`define BFCE_OFF_PARAM1    6'h10
`define BFCE_OFF_RESP      6'h14
`define BFCE_OFF_RDATA     6'h18
`define BFCE_OFF_RLEFT     6'h1C
`define BFCE_OFF_SEC       6'h20
`define BFCE_CTRL_GO       0
`define BFCE_STS_BUSY      0
`define BFCE_STS_RESP      1
`define BFCE_STS_RDV       2
`define BFCE_STS_SECURED   3
`define BFCE_STS_VERIFY    4

`endif

// >>> bfce_region.v
// Alignment, bounds and protection checks for a flash region
`timescale 1ns/1ps
module bfce_region #(
  parameter [31:0] FLASH_SIZE = 32'h00020000,
  parameter        NPROT      = 32
) (
  input  wire [31:0]      start,
  input  wire [31:0]      count,
  input  wire [NPROT-1:0] prot,
  output wire             misaligned,
  output wire             out_of_range,
  output wire             hits_prot,
  output wire             any_prot
);
  localparam [31:0] SZ = FLASH_SIZE / NPROT;

  wire [32:0]      end_a;
  wire [NPROT-1:0] hit;

  // ==========
  // Checks
  assign end_a        = {1'b0, start} + {1'b0, count};
  assign misaligned   = (start[1:0] != 2'h0) | (count[1:0] != 2'h0);
  assign out_of_range = end_a > {1'b0, FLASH_SIZE};
  assign any_prot     = |prot;

  genvar i;
  generate
    for (i = 0; i < NPROT; i = i + 1) begin : g_sec
      localparam [32:0] LO = {1'b0, SZ} * i;
      localparam [32:0] HI = {1'b0, SZ} * (i + 1);
      assign hit[i] = prot[i] & ({1'b0, start} < HI) & (end_a > LO);
    end
  endgenerate

  // Empty region touches nothing
  assign hits_prot = (count != 32'h0) & (|hit);
endmodule // bfce_region

// >>> bfce_sec.v
// Flash security register with mass erase enable decode
`timescale 1ns/1ps
`include "bfce_defines.vh"
module bfce_sec (
  input  wire       mclk,
  input  wire       rst_b,
  input  wire [7:0] stored_sec_byte,
  input  wire       sec_open,
  output wire [7:0] sec_reg,
  output wire       secured,
  output wire       mass_erase_enable_bit_ok
);
  reg [7:0] sec_q;
  reg       init_q;

  // ==========
  // Register: loads stored byte after reset
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sec_q  <= `BFCE_SEC_RST;
      init_q <= 1'b0;
    end else begin
      init_q <= 1'b1;
      if (!init_q) begin
        sec_q <= stored_sec_byte;
      end
      if (sec_open) begin
        sec_q[`BFCE_SEC_LSB+1:`BFCE_SEC_LSB] <= `BFCE_SEC_OPEN;
      end
    end
  end

  assign sec_reg = sec_q;
  assign secured =
    sec_q[`BFCE_SEC_LSB+1:`BFCE_SEC_LSB] != `BFCE_SEC_OPEN;
  assign mass_erase_enable_bit_ok =
    sec_q[`BFCE_MASS_ERASE_ENABLE_BIT_LSB+1:`BFCE_MASS_ERASE_ENABLE_BIT_LSB] != `BFCE_MASS_ERASE_ENABLE_BIT_OFF;
endmodule // bfce_sec

// >>> bfce_engine.v
// Flash boot command engine with Avalon-MM register slave
// Operation
// - Property write tag 0x0C carries property tag then new value.
// - Writing a read-only property leaves it and reports read-only.
// - Property write answers success, read-only, unknown or invalid.
// - Writes and erases have no data phase; response follows at once.
// - Property tag 0x0A is the writable write-verify setting.
// - Tag 0x01 erases whole flash, answering success or error.
// - Any protected region makes whole internal erase fail without erasing.
// - Successful whole internal erase opens the security register.
// - Whole erase memory id 0 selects internal, 1 external flash.
// - Region erase with low two bits set returns status 101.
// - Region outside flash space returns status 102.
// - Region touching protected part returns status 10200.
// - Region erase status is 0, 10200 or 101 to 105; the code also returns 4 for a bad frame or parameter count.
// - Tag 0x0D mass-erases everything, protected sectors included.
// - Then security opens and 0xFE is programmed at 0x40C.
// - Mass erase enable off makes unlocking erase fail.
// - Tag 0x03 returns count bytes from unsecured readable memory.
// - After read data a generic response gives the status.
`timescale 1ns/1ps
`include "bfce_defines.vh"
module bfce_engine #(
  parameter [31:0] FLASH_SIZE = 32'h00020000,
  parameter        NPROT      = 32
) (
  input  wire             mclk,
  input  wire             rst_b,
  input  wire [5:0]       avs_address,
  input  wire             avs_read,
  input  wire             avs_write,
  input  wire [31:0]      avs_writedata,
  input  wire [3:0]       avs_byteenable,
  output wire [31:0]      avs_readdata,
  output wire             avs_waitrequest,
  output wire             flash_req,
  output wire [2:0]       flash_cmd,
  output wire [31:0]      flash_addr,
  output wire [31:0]      flash_len,
  output wire [7:0]       flash_wbyte,
  input  wire             flash_done,
  input  wire [1:0]       flash_err,
  input  wire [NPROT-1:0] flash_prot,
  input  wire [7:0]       stored_sec_byte,
  output wire             mem_req,
  output wire [31:0]      mem_addr,
  input  wire [7:0]       mem_rdata,
  input  wire             mem_ack,
  output wire             write_verify,
  output wire             secured
);
  // ==========
  // States
  localparam [4:0] ST_IDLE  = 5'h01;
  localparam [4:0] ST_FLASH = 5'h02;
  localparam [4:0] ST_PROG  = 5'h04;
  localparam [4:0] ST_FETCH = 5'h08;
  localparam [4:0] ST_WAIT  = 5'h10;

  reg  [4:0]  state_q;
  reg  [31:0] hdr_q;
  reg  [31:0] frame_q;
  reg  [31:0] p0_q;
  reg  [31:0] p1_q;
  reg         verify_q;
  reg  [31:0] status_q;
  reg         resp_v_q;
  reg  [7:0]  rbyte_q;
  reg         rbyte_v_q;
  reg  [31:0] raddr_q;
  reg  [31:0] rleft_q;
  reg  [2:0]  fcmd_q;
  reg  [31:0] faddr_q;
  reg  [31:0] flen_q;
  reg  [7:0]  fbyte_q;
  reg         ack_q;
  reg  [31:0] rdata_q;
  reg  [31:0] rdata_d;
  reg         sec_open_q;

  wire        req;
  wire        acc;
  wire        wr_acc;
  wire        rd_acc;
  wire [31:0] be_m;
  wire        go;
  wire        resp_pop;
  wire        rd_pop;
  wire [7:0]  tag;
  wire [7:0]  pcnt;
  wire        frame_ok;
  wire [7:0]  sec_reg;
  wire        mass_erase_enable_bit_ok;
  wire        misaligned;
  wire        out_of_range;
  wire        hits_prot;
  wire        any_prot;
  wire [31:0] ferr_st;

  // ==========
  // Bus slave: one wait state per access
  assign req    = avs_read | avs_write;
  assign acc    = req & ack_q;
  assign wr_acc = avs_write & ack_q;
  assign rd_acc = avs_read & ack_q;
  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata    = rdata_q;
  assign be_m = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                 {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  assign go = wr_acc & (avs_address == `BFCE_OFF_CTRL) &
              avs_byteenable[0] & avs_writedata[`BFCE_CTRL_GO];
  assign resp_pop = rd_acc & (avs_address == `BFCE_OFF_RESP);
  assign rd_pop   = rd_acc & (avs_address == `BFCE_OFF_RDATA);

  always @* begin
    rdata_d = 32'h0;
    case (avs_address)
      `BFCE_OFF_CTRL: begin
        rdata_d[`BFCE_STS_BUSY]    = ~state_q[0];
        rdata_d[`BFCE_STS_RESP]    = resp_v_q;
        rdata_d[`BFCE_STS_RDV]     = rbyte_v_q;
        rdata_d[`BFCE_STS_SECURED] = secured;
        rdata_d[`BFCE_STS_VERIFY]  = verify_q;
      end
      `BFCE_OFF_HDR:    rdata_d = hdr_q;
      `BFCE_OFF_FRAME:  rdata_d = frame_q;
      `BFCE_OFF_PARAM0: rdata_d = p0_q;
      `BFCE_OFF_PARAM1: rdata_d = p1_q;
      `BFCE_OFF_RESP:   rdata_d = status_q;
      `BFCE_OFF_RDATA:  rdata_d = {23'h0, rbyte_v_q, rbyte_q};
      `BFCE_OFF_RLEFT:  rdata_d = rleft_q;
      `BFCE_OFF_SEC:    rdata_d = {24'h0, sec_reg};
      default:          rdata_d = 32'h0;
    endcase
  end

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // ==========
  // Command registers, writable only while idle
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hdr_q   <= 32'h0;
      frame_q <= 32'h0;
      p0_q    <= 32'h0;
      p1_q    <= 32'h0;
    end else if (wr_acc & state_q[0]) begin
      case (avs_address)
        `BFCE_OFF_HDR:
          hdr_q <= (hdr_q & ~be_m) | (avs_writedata & be_m);
        `BFCE_OFF_FRAME:
          frame_q <= (frame_q & ~be_m) | (avs_writedata & be_m);
        `BFCE_OFF_PARAM0:
          p0_q <= (p0_q & ~be_m) | (avs_writedata & be_m);
        `BFCE_OFF_PARAM1:
          p1_q <= (p1_q & ~be_m) | (avs_writedata & be_m);
        default: begin
        end
      endcase
    end
  end

  // ==========
  // Decode and checks
  assign tag  = hdr_q[7:0];
  assign pcnt = hdr_q[31:24];
  // CRC is not checked here; transport owns it
  assign frame_ok = (frame_q[7:0] == `BFCE_FRM_START) &
                    (frame_q[15:8] == `BFCE_FRM_CMD_TYPE) &
                    (frame_q[31:16] ==
                     `BFCE_HDR_BYTES + {6'h0, pcnt, 2'h0});

  assign ferr_st = (flash_err == 2'h1) ? `BFCE_ST_ACCESS :
                   (flash_err == 2'h2) ? `BFCE_ST_PROT :
                   `BFCE_ST_FAIL;

  bfce_region #(
    .FLASH_SIZE (FLASH_SIZE),
    .NPROT      (NPROT)
  ) u_region (
    .start        (p0_q),
    .count        (p1_q),
    .prot         (flash_prot),
    .misaligned   (misaligned),
    .out_of_range (out_of_range),
    .hits_prot    (hits_prot),
    .any_prot     (any_prot)
  );

  bfce_sec u_sec (
    .mclk            (mclk),
    .rst_b           (rst_b),
    .stored_sec_byte (stored_sec_byte),
    .sec_open        (sec_open_q),
    .sec_reg         (sec_reg),
    .secured         (secured),
    .mass_erase_enable_bit_ok         (mass_erase_enable_bit_ok)
  );

  // ==========
  // Command sequencer
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q    <= ST_IDLE;
      verify_q   <= `BFCE_VERIFY_RST;
      status_q   <= `BFCE_ST_OK;
      resp_v_q   <= 1'b0;
      rbyte_q    <= 8'h0;
      rbyte_v_q  <= 1'b0;
      raddr_q    <= 32'h0;
      rleft_q    <= 32'h0;
      fcmd_q     <= 3'h0;
      faddr_q    <= 32'h0;
      flen_q     <= 32'h0;
      fbyte_q    <= 8'h0;
      sec_open_q <= 1'b0;
    end else begin
      sec_open_q <= 1'b0;
      // Clears first so a same-cycle set wins
      if (resp_pop) begin
        resp_v_q <= 1'b0;
      end
      if (rd_pop) begin
        rbyte_v_q <= 1'b0;
      end
      case (state_q)
        ST_IDLE: begin
          // Go is ignored until the last answer is taken
          if (go & ~resp_v_q) begin
            resp_v_q <= 1'b1;
            status_q <= `BFCE_ST_OK;
            if (!frame_ok) begin
              status_q <= `BFCE_ST_INVARG;
            end else begin
              case (tag)
                `BFCE_TAG_PROP_WR: begin
                  if (pcnt != 8'h2) begin
                    status_q <= `BFCE_ST_INVARG;
                  end else if (p0_q == `BFCE_PROP_VERIFY) begin
                    if (p1_q[31:1] != 31'h0) begin
                      status_q <= `BFCE_ST_INVARG;
                    end else begin
                      verify_q <= p1_q[0];
                    end
                  end else if (p0_q != 32'h0 &&
                               p0_q <= `BFCE_PROP_MAX) begin
                    status_q <= `BFCE_ST_READONLY;
                  end else begin
                    status_q <= `BFCE_ST_UNKPROP;
                  end
                end
                `BFCE_TAG_ERASE_ALL: begin
                  if (pcnt > 8'h1 || (pcnt == 8'h1 &&
                      p0_q != `BFCE_MEM_INT &&
                      p0_q != `BFCE_MEM_EXT)) begin
                    status_q <= `BFCE_ST_INVARG;
                  end else if (pcnt == 8'h1 &&
                               p0_q == `BFCE_MEM_EXT) begin
                    resp_v_q <= 1'b0;
                    fcmd_q   <= `BFCE_FC_ERASE_EXT;
                    state_q  <= ST_FLASH;
                  end else if (any_prot) begin
                    status_q <= `BFCE_ST_PROT;
                  end else begin
                    resp_v_q <= 1'b0;
                    fcmd_q   <= `BFCE_FC_ERASE_INT;
                    state_q  <= ST_FLASH;
                  end
                end
                `BFCE_TAG_REGION: begin
                  if (pcnt != 8'h2) begin
                    status_q <= `BFCE_ST_INVARG;
                  end else if (misaligned) begin
                    status_q <= `BFCE_ST_ALIGN;
                  end else if (out_of_range) begin
                    status_q <= `BFCE_ST_ADDR;
                  end else if (hits_prot) begin
                    status_q <= `BFCE_ST_RANGE;
                  end else if (p1_q != 32'h0) begin
                    resp_v_q <= 1'b0;
                    fcmd_q   <= `BFCE_FC_REGION;
                    faddr_q  <= p0_q;
                    flen_q   <= p1_q;
                    state_q  <= ST_FLASH;
                  end
                end
                `BFCE_TAG_UNLOCK: begin
                  if (pcnt != 8'h0) begin
                    status_q <= `BFCE_ST_INVARG;
                  end else if (!mass_erase_enable_bit_ok) begin
                    status_q <= `BFCE_ST_FAIL;
                  end else begin
                    resp_v_q <= 1'b0;
                    fcmd_q   <= `BFCE_FC_UNLOCK;
                    state_q  <= ST_FLASH;
                  end
                end
                `BFCE_TAG_READ: begin
                  if (pcnt != 8'h2) begin
                    status_q <= `BFCE_ST_INVARG;
                  end else if (secured && p0_q < FLASH_SIZE) begin
                    status_q <= `BFCE_ST_RANGE;
                  end else begin
                    raddr_q <= p0_q;
                    rleft_q <= p1_q;
                    if (p1_q != 32'h0) begin
                      resp_v_q <= 1'b0;
                      state_q  <= ST_FETCH;
                    end
                  end
                end
                default: status_q <= `BFCE_ST_UNKCMD;
              endcase
            end
          end
        end
        ST_FLASH: begin
          // No data phase: answer right after the flash op
          if (flash_done) begin
            if (flash_err != 2'h0) begin
              status_q <= ferr_st;
              resp_v_q <= 1'b1;
              state_q  <= ST_IDLE;
            end else if (fcmd_q == `BFCE_FC_UNLOCK) begin
              sec_open_q <= 1'b1;
              fcmd_q     <= `BFCE_FC_PROG;
              faddr_q    <= `BFCE_SEC_ADDR;
              fbyte_q    <= `BFCE_SEC_UNSEC;
              state_q    <= ST_PROG;
            end else begin
              if (fcmd_q == `BFCE_FC_ERASE_INT) begin
                sec_open_q <= 1'b1;
              end
              status_q <= `BFCE_ST_OK;
              resp_v_q <= 1'b1;
              state_q  <= ST_IDLE;
            end
          end
        end
        ST_PROG: begin
          if (flash_done) begin
            status_q <= (flash_err != 2'h0) ? ferr_st :
                        `BFCE_ST_OK;
            resp_v_q <= 1'b1;
            state_q  <= ST_IDLE;
          end
        end
        ST_FETCH: begin
          if (mem_ack) begin
            rbyte_q   <= mem_rdata;
            rbyte_v_q <= 1'b1;
            state_q   <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // The host pulls each byte; nothing is pushed
          if (rd_pop & rbyte_v_q) begin
            raddr_q <= raddr_q + 32'h1;
            rleft_q <= rleft_q - 32'h1;
            if (rleft_q == 32'h1) begin
              status_q <= `BFCE_ST_OK;
              resp_v_q <= 1'b1;
              state_q  <= ST_IDLE;
            end else begin
              state_q <= ST_FETCH;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========
  // Outward ports
  assign flash_req    = state_q[1] | state_q[2];
  assign flash_cmd    = fcmd_q;
  assign flash_addr   = faddr_q;
  assign flash_len    = flen_q;
  assign flash_wbyte  = fbyte_q;
  assign mem_req      = state_q[3];
  assign mem_addr     = raddr_q;
  assign write_verify = verify_q;
endmodule // bfce_engine

// >>> bfce_engine_sva.sv
// Port assertions for the flash boot command engine
`timescale 1ns/1ps
`include "bfce_defines.vh"
module bfce_engine_sva #(
  parameter [31:0] FLASH_SIZE = 32'h00020000,
  parameter        NPROT      = 32
) (
  input wire             mclk,
  input wire             rst_b,
  input wire [5:0]       avs_address,
  input wire             avs_read,
  input wire             avs_write,
  input wire [31:0]      avs_writedata,
  input wire [3:0]       avs_byteenable,
  input wire [31:0]      avs_readdata,
  input wire             avs_waitrequest,
  input wire             flash_req,
  input wire [2:0]       flash_cmd,
  input wire [31:0]      flash_addr,
  input wire [31:0]      flash_len,
  input wire [7:0]       flash_wbyte,
  input wire             flash_done,
  input wire [1:0]       flash_err,
  input wire [NPROT-1:0] flash_prot,
  input wire [7:0]       stored_sec_byte,
  input wire             mem_req,
  input wire [31:0]      mem_addr,
  input wire [7:0]       mem_rdata,
  input wire             mem_ack,
  input wire             write_verify,
  input wire             secured
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // ==========
  // Flash sequencing
  sequence s_unl;
    flash_req && flash_cmd == `BFCE_FC_UNLOCK && flash_done && !flash_err;
  endsequence
  sequence s_prog;
    flash_req && flash_cmd == `BFCE_FC_PROG
      && flash_addr == `BFCE_SEC_ADDR && flash_wbyte == `BFCE_SEC_UNSEC;
  endsequence
  property p_seq; s_unl |=> s_prog; endproperty
  a_seq: assert property (p_seq) else $error("no byte program");
  property p_open; s_unl |-> ##[1:2] !secured; endproperty
  a_open: assert property (p_open) else $error("still secured");
  property p_erase;
    flash_req && flash_cmd == `BFCE_FC_ERASE_INT && flash_done && !flash_err
      |-> ##[1:2] !secured;
  endproperty
  a_erase: assert property (p_erase) else $error("erase kept lock");
  property p_reply;
    flash_req && flash_done && (flash_cmd != `BFCE_FC_UNLOCK || flash_err)
      |=> !flash_req;
  endproperty
  a_reply: assert property (p_reply) else $error("op not ended");
  // Protection must stop the op before it starts, not after
  property p_prot;
    $rose(flash_req) && flash_cmd == `BFCE_FC_ERASE_INT |-> !flash_prot;
  endproperty
  a_prot: assert property (p_prot) else $error("prot erase");
  property p_align;
    $rose(flash_req) && flash_cmd == `BFCE_FC_REGION
      |-> !flash_addr[1:0] && !flash_len[1:0];
  endproperty
  a_align: assert property (p_align) else $error("misaligned");
  property p_range;
    $rose(flash_req) && flash_cmd == `BFCE_FC_REGION
      |-> {1'b0, flash_addr} + {1'b0, flash_len} <= {1'b0, FLASH_SIZE};
  endproperty
  a_range: assert property (p_range) else $error("too big");
  property p_mass_erase_enable_bit;
    $rose(flash_req) && flash_cmd == `BFCE_FC_UNLOCK
      |-> stored_sec_byte[5:4] != `BFCE_MASS_ERASE_ENABLE_BIT_OFF;
  endproperty
  a_mass_erase_enable_bit: assert property (p_mass_erase_enable_bit) else $error("no mass erase");
  property p_one; flash_req |-> !mem_req; endproperty
  a_one: assert property (p_one) else $error("two ops at once");
  property p_bus;
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_bus: assert property (p_bus) else $error("bus wait wrong");
endmodule // bfce_engine_sva
bind bfce_engine bfce_engine_sva #(.FLASH_SIZE(FLASH_SIZE), .NPROT(NPROT))
  bfce_engine_sva_i (.*);

// >>> bfce_far.sv
// Flash controller and memory model on the engine's far side
`timescale 1ns/1ps
module bfce_far (
  input  wire        mclk,
  input  wire        rst_b,
  input  wire        flash_req,
  input  wire [1:0]  err_sel,
  input  wire        slow,
  input  wire        mem_req,
  input  wire [31:0] mem_addr,
  output reg         flash_done,
  output reg  [1:0]  flash_err,
  output reg  [7:0]  mem_rdata,
  output reg         mem_ack
);
  reg  [3:0] cnt_q;
  reg  [3:0] mcnt_q;
  wire       fgo = flash_req && !flash_done && cnt_q == (slow ? 4'h6 : 4'h0);
  wire       mgo = mem_req && !mem_ack && mcnt_q == (slow ? 4'h3 : 4'h0);
  // ==========
  // Responders
  // Outside a pulse the data toggle, so stale values never look valid
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 4'h0;
      mcnt_q <= 4'h0;
      flash_done <= 1'b0;
      flash_err <= 2'h0;
      mem_ack <= 1'b0;
      mem_rdata <= 8'h00;
    end else begin
      cnt_q <= (!flash_req || flash_done) ? 4'h0 : cnt_q + 4'h1;
      mcnt_q <= (!mem_req || mem_ack) ? 4'h0 : mcnt_q + 4'h1;
      flash_done <= fgo;
      flash_err <= fgo ? err_sel : ~flash_err;
      mem_ack <= mgo;
      mem_rdata <= mgo ? mem_addr[7:0] ^ 8'hA5 : ~mem_rdata;
    end
  end
endmodule // bfce_far

// >>> bfce_engine_tb.sv
// Self-checking bench for the flash boot command engine
`timescale 1ns/1ps
`include "bfce_defines.vh"
module bfce_engine_tb;
  localparam [31:0] FS = 32'h00020000;
  reg          mclk = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  reg          slow = 1'b0;
  reg  [5:0]   avs_address = 6'h00;
  reg  [31:0]  avs_writedata = 32'h0, flash_prot = 32'h0, rd_q, a, c;
  reg  [7:0]   sec_byte = 8'hFF;
  reg  [1:0]   err_sel = 2'h0;
  reg  [15:0]  bad = 16'h0;
  wire [31:0]  avs_readdata, flash_addr, flash_len, mem_addr;
  wire [7:0]   flash_wbyte, mem_rdata;
  wire [2:0]   flash_cmd;
  wire [1:0]   flash_err;
  wire         avs_waitrequest, flash_req, flash_done, mem_req, mem_ack;
  wire         write_verify, secured;
  integer      errors = 0, n_compared = 0, seed = 32'h2B3EFEC2, j, k, i;
  reg  [31:0]  exp_q[$];
  always #2.5 mclk = ~mclk;
  bfce_engine #(.FLASH_SIZE(FS), .NPROT(32)) bfce_engine_i (
    .mclk(mclk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .flash_req(flash_req), .flash_cmd(flash_cmd), .flash_addr(flash_addr),
    .flash_len(flash_len), .flash_wbyte(flash_wbyte),
    .flash_done(flash_done), .flash_err(flash_err),
    .flash_prot(flash_prot), .stored_sec_byte(sec_byte),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .write_verify(write_verify), .secured(secured));
  bfce_far bfce_far_i (
    .mclk(mclk), .rst_b(rst_b), .flash_req(flash_req), .err_sel(err_sel),
    .slow(slow), .mem_req(mem_req), .mem_addr(mem_addr),
    .flash_done(flash_done), .flash_err(flash_err),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  // ==========
  // Checking and bus tasks
  task print_verdict;
    begin
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // Held until waitrequest is seen low at a rising edge
  task bus(input w, input [5:0] ad, input [31:0] d);
    begin
      @(posedge mclk);
      avs_address <= ad;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      k = 0;
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0 && k < 100) begin
        k = k + 1;
        @(posedge mclk);
      end
      if (k == 100) chk(32'h1, 32'h0);
      if (k == 100) print_verdict;
      rd_q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  task rdx(input [5:0] ad, input [31:0] v);
    begin
      exp_q.push_back(v);
      bus(1'b0, ad, 32'h0);
    end
  endtask
  task wt(input integer b);
    begin
      bus(1'b0, `BFCE_OFF_CTRL, 32'h0);
      for (j = 0; j < 200 && rd_q[b] !== 1'b1; j = j + 1)
        bus(1'b0, `BFCE_OFF_CTRL, 32'h0);
      if (j == 200) chk(32'h1, 32'h0);
      if (j == 200) print_verdict;
    end
  endtask
  task go(input [7:0] t, input [7:0] n, input [31:0] p0, input [31:0] p1);
    begin
      bus(1'b1, `BFCE_OFF_HDR, {n, 16'h0000, t});
      bus(1'b1, `BFCE_OFF_FRAME, {`BFCE_HDR_BYTES + {6'h00, n, 2'h0} + bad,
        `BFCE_FRM_CMD_TYPE, `BFCE_FRM_START});
      bus(1'b1, `BFCE_OFF_PARAM0, p0);
      bus(1'b1, `BFCE_OFF_PARAM1, p1);
      bus(1'b1, `BFCE_OFF_CTRL, 32'h1);
    end
  endtask
  task cmd(input [7:0] t, input [7:0] n, input [31:0] p0, input [31:0] p1,
           input [31:0] st);
    begin
      go(t, n, p0, p1);
      wt(1);
      rdx(`BFCE_OFF_RESP, st);
    end
  endtask
  task rst(input [7:0] s);
    begin
      @(posedge mclk);
      rst_b <= 1'b0;
      sec_byte <= s;
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (2) @(posedge mclk);
    end
  endtask
  always @(negedge mclk)
    if (avs_read && !avs_waitrequest && avs_address >= `BFCE_OFF_RESP
        && avs_address != `BFCE_OFF_RLEFT)
      chk(avs_readdata, exp_q.pop_front());
  // ==========
  // Scenarios
  initial begin
    rst(8'hFF);
    rdx(`BFCE_OFF_SEC, 32'hFF);
    rdx(6'h24, 32'h0);
    cmd(`BFCE_TAG_READ, 2, 32'h100, 32'h4, `BFCE_ST_RANGE);
    cmd(`BFCE_TAG_PROP_WR, 2, 32'hA, 32'h1, `BFCE_ST_OK);
    chk({31'h0, write_verify}, 32'h1);
    cmd(`BFCE_TAG_PROP_WR, 2, 32'hA, 32'h2, `BFCE_ST_INVARG);
    cmd(`BFCE_TAG_PROP_WR, 2, 32'h3, 32'h0, `BFCE_ST_READONLY);
    cmd(`BFCE_TAG_PROP_WR, 2, 32'h20, 32'h0, `BFCE_ST_UNKPROP);
    chk({31'h0, write_verify}, 32'h1);
    bad = 16'h4;
    cmd(`BFCE_TAG_PROP_WR, 2, 32'hA, 32'h0, `BFCE_ST_INVARG);
    bad = 16'h0;
    cmd(`BFCE_TAG_REGION, 2, 32'h102, 32'h100, `BFCE_ST_ALIGN);
    cmd(`BFCE_TAG_REGION, 2, 32'h100, 32'h101, `BFCE_ST_ALIGN);
    cmd(`BFCE_TAG_REGION, 2, FS - 32'h4, 32'h8, `BFCE_ST_ADDR);
    for (i = 0; i < 4; i = i + 1) begin
      err_sel <= i[1:0];
      slow <= i[0];
      cmd(`BFCE_TAG_REGION, 2, 32'h400, 32'h400,
          i ? 32'h66 + i : 32'h0);
    end
    err_sel <= 2'h0;
    flash_prot <= 32'h1;
    cmd(`BFCE_TAG_REGION, 2, 32'h0, 32'h100, `BFCE_ST_RANGE);
    cmd(`BFCE_TAG_ERASE_ALL, 1, `BFCE_MEM_INT, 0, `BFCE_ST_PROT);
    chk({31'h0, secured}, 32'h1);
    cmd(`BFCE_TAG_ERASE_ALL, 1, `BFCE_MEM_EXT, 0, `BFCE_ST_OK);
    flash_prot <= 32'h0;
    cmd(`BFCE_TAG_ERASE_ALL, 1, `BFCE_MEM_INT, 0, `BFCE_ST_OK);
    chk({31'h0, secured}, 32'h0);
    a = $random(seed) & 32'h1FFF0;
    c = 32'h2 + ($random(seed) & 32'h3);
    go(`BFCE_TAG_READ, 2, a, c);
    for (i = 0; i < c; i = i + 1) begin
      wt(2);
      rdx(`BFCE_OFF_RDATA,
          {23'h0, 1'b1, 8'hA5 ^ (a[7:0] + i[7:0])});
    end
    wt(1);
    rdx(`BFCE_OFF_RESP, `BFCE_ST_OK);
    rst(8'hEF);
    rdx(`BFCE_OFF_SEC, 32'hEF);
    cmd(`BFCE_TAG_UNLOCK, 0, 0, 0, `BFCE_ST_FAIL);
    rst(8'hFF);
    chk({31'h0, secured}, 32'h1);
    flash_prot <= 32'hFFFFFFFF;
    cmd(`BFCE_TAG_UNLOCK, 0, 0, 0, `BFCE_ST_OK);
    chk({31'h0, secured}, 32'h0);
    print_verdict;
  end
endmodule // bfce_engine_tb
